// File: design/lmu_pkg.sv
package lmu_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL1  = 8'h00;
   localparam logic [7:0] OFS_CTRL2  = 8'h04;
   localparam logic [7:0] OFS_CTRL3  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_DATA   = 8'h10;
   localparam logic [7:0] OFS_BAUD   = 8'h14;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int C1_RX9 = 7;
   localparam int C1_TX9 = 6;
   localparam int C1_SLP = 5;
   localparam int C1_NINE = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_PEN = 2;
   localparam int C1_ODD = 1;
   localparam int C1_PIE = 0;
   localparam int C2_TIE = 7;
   localparam int C2_TX_DONE_IRQ_ENABLE = 6;
   localparam int C2_RIE = 5;
   localparam int C2_IDLE_IRQ_ENABLE = 4;
   localparam int C2_TE = 3;
   localparam int C2_RE = 2;
   localparam int C2_MUTE = 1;
   localparam int C2_BRK = 0;
   localparam int C3_LIN = 6;
   localparam int C3_CKEN = 3;
   localparam int C3_IDLE_LEVEL_HIGH = 2;
   localparam int C3_EARLY_EDGE_PHASE = 1;
   localparam int C3_LAST_BIT_PULSE_ENABLE = 0;
   localparam logic [7:0] C3_WMASK = 8'h4F;
   localparam int ST_TXE = 7;
   localparam int ST_TC = 6;
   localparam int ST_RXF = 5;
   localparam int ST_IDLE = 4;
   localparam int ST_OVR = 3;
   localparam int ST_PAR = 0;
   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL2 = 8'h00;
   localparam logic [7:0] RST_CTRL3 = 8'h00;
   localparam logic [15:0] RST_BAUD = 16'h0010;
   localparam logic [3:0] BRK_LEN_8 = 4'hA;
   localparam logic [3:0] BRK_LEN_9 = 4'hB;
   localparam logic [3:0] BRK_LEN_LIN8 = 4'hD;
   localparam logic [3:0] BRK_LEN_LIN9 = 4'hE;
   localparam logic [3:0] SAMPLES = 4'hF;
   localparam logic [3:0] HALF_SAMPLES = 4'h7;
   typedef enum logic [2:0] {
      TX_OFF, TX_LEAD, TX_IDLE, TX_FRAME, TX_PRE, TX_BREAK
   } lmu_tx_st_t;
endpackage

// File: design/lmu_baud.sv
`timescale 1ns/100ps
`default_nettype none
module lmu_baud #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Control
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   // Sixteenth-bit tick
   output logic              tick
);
   logic [W-1:0] cnt_r;
   wire          at_end = (cnt_r == '0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= run && at_end;
         cnt_r <= (!run || at_end) ? div : cnt_r - 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: design/lmu_rx.sv
`timescale 1ns/100ps
`default_nettype none
module lmu_rx (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Control
   input  wire logic       tick,
   input  wire logic       enable,
   input  wire logic       nine,
   input  wire logic       par_en,
   input  wire logic       par_odd,
   // Serial input
   input  wire logic       rxd,
   // Received word
   output logic            done,
   output logic [8:0]      word,
   output logic            par_bad,
   output logic            idle_seen
);
   logic       busy_r;
   logic [3:0] bit_r;
   logic [3:0] smp_r;
   logic [9:0] sh_r;
   logic [3:0] idle_r;
   logic       pen_r;
   logic       podd_r;
   logic       nine_r;
   wire  [3:0] last_bit = nine_r ? 4'hA : 4'h9;
   wire        mid = (smp_r == lmu_pkg::HALF_SAMPLES);
   wire        par_calc = ^(nine_r ? sh_r[9:1] : {1'b0, sh_r[9:2]});
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_r <= 1'b0;
         bit_r <= '0;
         smp_r <= '0;
         sh_r <= '0;
         idle_r <= '0;
         pen_r <= 1'b0;
         podd_r <= 1'b0;
         nine_r <= 1'b0;
         done <= 1'b0;
         word <= '0;
         par_bad <= 1'b0;
         idle_seen <= 1'b0;
      end else begin
         done <= 1'b0;
         idle_seen <= 1'b0;
         if (!enable) begin
            busy_r <= 1'b0;
            idle_r <= '0;
         end else if (tick) begin
            if (!busy_r) begin
               // Start bit hunt; parity options latched per byte
               if (!rxd) begin
                  busy_r <= 1'b1;
                  smp_r <= '0;
                  bit_r <= '0;
                  pen_r <= par_en;
                  podd_r <= par_odd;
                  nine_r <= nine;
               end
            end else begin
               smp_r <= smp_r + 4'h1;
               if (mid) begin
                  sh_r <= {rxd, sh_r[9:1]};
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == last_bit) begin
                     busy_r <= 1'b0;
                     done <= 1'b1;
                     idle_r <= '0;
                     // Ninth bit kept in the word's top bit
                     word <= nine_r ? sh_r[9:1] : {1'b0, sh_r[9:2]};
                     par_bad <= pen_r && (par_calc != podd_r);
                  end
               end
            end
            if (!busy_r && rxd && idle_r != 4'hF) begin
               idle_r <= idle_r + 4'h1;
               if (idle_r == 4'hE)
                  idle_seen <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: design/lmu_top.sv
`timescale 1ns/100ps
`default_nettype none
module lmu_top #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial pins
   input  wire logic        rxd,
   output logic             txd,
   output logic             txd_oen,
   output logic             sync_clock_out,
   output logic             sync_clock_oen,
   // Interface interrupt
   output logic             irq
);
   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   logic        wr_r;
   logic        rd_r;
   logic [7:0]  adr_r;
   logic [7:0]  ctrl1_r;
   logic [7:0]  ctrl2_r;
   logic [7:0]  ctrl3_r;
   logic [15:0] baud_r;
   logic [8:0]  rdat_r;
   logic [7:0]  tdat_r;
   logic        txe_r;
   logic        tc_r;
   logic        rxf_r;
   logic        idle_r;
   logic        ovr_r;
   logic        par_r;
   logic        stat_rd_r;
   wire         take = hsel && hready && htrans[1];
   wire         w_c1 = wr_r && adr_r == lmu_pkg::OFS_CTRL1;
   wire         w_c2 = wr_r && adr_r == lmu_pkg::OFS_CTRL2;
   wire         w_c3 = wr_r && adr_r == lmu_pkg::OFS_CTRL3;
   wire         w_dat = wr_r && adr_r == lmu_pkg::OFS_DATA;
   wire         w_bd = wr_r && adr_r == lmu_pkg::OFS_BAUD;
   wire         r_dat = rd_r && adr_r == lmu_pkg::OFS_DATA;
   wire         r_st = rd_r && adr_r == lmu_pkg::OFS_STATUS;
   wire [7:0]   status = {txe_r, tc_r, rxf_r, idle_r, ovr_r, 2'b00, par_r};
   wire [7:0]   rd_c1 = {rdat_r[8], ctrl1_r[6:0]};
   wire [31:0]  rd_mux =
      (adr_r == lmu_pkg::OFS_CTRL1)  ? {24'h000000, rd_c1} :
      (adr_r == lmu_pkg::OFS_CTRL2)  ? {24'h000000, ctrl2_r} :
      (adr_r == lmu_pkg::OFS_CTRL3)  ? {24'h000000, ctrl3_r} :
      (adr_r == lmu_pkg::OFS_STATUS) ? {24'h000000, status} :
      (adr_r == lmu_pkg::OFS_DATA)   ? {24'h000000, rdat_r[7:0]} :
      (adr_r == lmu_pkg::OFS_BAUD)   ? {16'h0000, baud_r} : 32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_mux;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         adr_r <= '0;
      end else begin
         wr_r <= take && hwrite;
         rd_r <= take && !hwrite;
         adr_r <= take ? haddr : adr_r;
      end
   end
   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   wire nine = ctrl1_r[lmu_pkg::C1_NINE];
   wire asleep = ctrl1_r[lmu_pkg::C1_SLP];
   wire wake_mark = ctrl1_r[lmu_pkg::C1_WAKE];
   wire tx_en = ctrl2_r[lmu_pkg::C2_TE];
   wire rx_en = ctrl2_r[lmu_pkg::C2_RE];
   wire brk = ctrl2_r[lmu_pkg::C2_BRK];
   wire idle_level_high = ctrl3_r[lmu_pkg::C3_IDLE_LEVEL_HIGH];
   wire early_edge_phase = ctrl3_r[lmu_pkg::C3_EARLY_EDGE_PHASE];
   logic       tx_busy;
   logic       rx_done;
   logic [8:0] rx_word;
   logic       rx_pbad;
   logic       rx_idle;
   logic       mute_wake;
   logic       tick;
   // ---------------------------------------------------------------
   // Baud tick and receiver
   // ---------------------------------------------------------------
   // Sleep gates the tick only once the transmitter is off or idle; a receive in flight is not waited for
   wire run = !(asleep && !tx_busy);
   lmu_baud #(.W(DIV_W)) u_baud (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (run),
      .div     (baud_r[DIV_W-1:0]),
      .tick    (tick)
   );
   lmu_rx u_rx (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (tick),
      .enable    (rx_en),
      .nine      (nine),
      .par_en    (ctrl1_r[lmu_pkg::C1_PEN]),
      .par_odd   (ctrl1_r[lmu_pkg::C1_ODD]),
      .rxd       (rxd),
      .done      (rx_done),
      .word      (rx_word),
      .par_bad   (rx_pbad),
      .idle_seen (rx_idle)
   );
   wire muted = ctrl2_r[lmu_pkg::C2_MUTE];
   wire mark_bit = nine ? rx_word[8] : rx_word[7];
   // idle line or address mark ends mute mode
   assign mute_wake = muted &&
      (wake_mark ? (rx_done && rx_word[8:0] != 9'h000 &&
                    (nine ? rx_word[8] : rx_word[7]))
                 : rx_idle);
   wire rx_store = rx_done && (!muted || (wake_mark && mark_bit));
   // Mute bit locked against software in address mode while full
   wire mute_lock = wake_mark && rxf_r;
   wire [7:0] c2_wr = {hwdata[7:2],
                       mute_lock ? muted : hwdata[1], hwdata[0]};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1_r <= lmu_pkg::RST_CTRL1;
         ctrl2_r <= lmu_pkg::RST_CTRL2;
         ctrl3_r <= lmu_pkg::RST_CTRL3;
         baud_r <= lmu_pkg::RST_BAUD;
      end else begin
         if (w_c1)
            ctrl1_r <= hwdata[7:0];
         if (w_c3)
            ctrl3_r <= hwdata[7:0] & lmu_pkg::C3_WMASK;
         if (w_bd)
            baud_r <= hwdata[15:0];
         if (w_c2)
            ctrl2_r <= c2_wr;
         else if (mute_wake)
            ctrl2_r[lmu_pkg::C2_MUTE] <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Status flags; set wins over the software clear sequence
   // ---------------------------------------------------------------
   logic tx_load;
   logic tx_fin;
   wire  rd_clr = stat_rd_r && r_dat;
   wire  wr_clr = stat_rd_r && w_dat;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txe_r <= 1'b1;
         tc_r <= 1'b1;
         rxf_r <= 1'b0;
         idle_r <= 1'b0;
         ovr_r <= 1'b0;
         par_r <= 1'b0;
         stat_rd_r <= 1'b0;
         rdat_r <= '0;
         tdat_r <= '0;
      end else begin
         stat_rd_r <= r_st ? 1'b1 : ((r_dat || w_dat) ? 1'b0 : stat_rd_r);
         if (w_dat)
            tdat_r <= hwdata[7:0];
         txe_r <= tx_load | (txe_r & !w_dat);
         tc_r <= tx_fin | (tc_r & !wr_clr);
         if (rx_store && !rxf_r) begin
            rdat_r <= rx_word;
            par_r <= rx_pbad;
         end else if (rd_clr) begin
            par_r <= 1'b0;
         end
         rxf_r <= (rx_store && !rxf_r) | (rxf_r & !r_dat);
         ovr_r <= (rx_store && rxf_r) | (ovr_r & !rd_clr);
         idle_r <= rx_idle | (idle_r & !rd_clr);
      end
   end
   // every enabled event drives the one line
   assign irq = (ctrl1_r[lmu_pkg::C1_PIE] & par_r)
      | (ctrl2_r[lmu_pkg::C2_TIE] & txe_r)
      | (ctrl2_r[lmu_pkg::C2_TX_DONE_IRQ_ENABLE] & tc_r)
      | (ctrl2_r[lmu_pkg::C2_RIE] & (rxf_r | ovr_r))
      | (ctrl2_r[lmu_pkg::C2_IDLE_IRQ_ENABLE] & idle_r);
   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   lmu_pkg::lmu_tx_st_t st_r;
   lmu_pkg::lmu_tx_st_t st_nxt;
   logic [3:0]  smp_r;
   logic [3:0]  bit_r;
   logic [10:0] sh_r;
   logic        nine_r;
   logic        pre_r;
   logic        brk_r;
   logic        brk_seen_r;
   logic        te_d_r;
   wire  bit_end = tick && smp_r == lmu_pkg::SAMPLES;
   wire  [3:0] frm_len = nine_r ? 4'hB : 4'hA;
   wire  [3:0] brk_len = ctrl3_r[lmu_pkg::C3_LIN]
      ? (nine ? lmu_pkg::BRK_LEN_LIN9 : lmu_pkg::BRK_LEN_LIN8)
      : (nine ? lmu_pkg::BRK_LEN_9 : lmu_pkg::BRK_LEN_8);
   wire  [3:0] cur_len = (st_r == lmu_pkg::TX_FRAME) ? frm_len : brk_len;
   wire  [8:0] dat9 = {ctrl1_r[lmu_pkg::C1_TX9], tdat_r};
   wire  par_g = ^(nine ? dat9[7:0] : {1'b0, dat9[6:0]})
                 ^ ctrl1_r[lmu_pkg::C1_ODD];
   wire  [8:0] dat_p = !ctrl1_r[lmu_pkg::C1_PEN] ? dat9 :
                       nine ? {par_g, dat9[7:0]}
                            : {1'b0, par_g, dat9[6:0]};
   wire  want_brk = brk || brk_seen_r;
   assign tx_busy = st_r != lmu_pkg::TX_OFF && st_r != lmu_pkg::TX_IDLE;
   assign tx_load = st_r == lmu_pkg::TX_IDLE && !want_brk && !pre_r
                    && !txe_r && !asleep;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         lmu_pkg::TX_OFF:
            if (tx_en)
               st_nxt = lmu_pkg::TX_LEAD;
         lmu_pkg::TX_LEAD:
            if (bit_end)
               st_nxt = lmu_pkg::TX_IDLE;
         lmu_pkg::TX_IDLE:
            if (!tx_en)
               st_nxt = lmu_pkg::TX_OFF;
            else if (pre_r)
               st_nxt = lmu_pkg::TX_PRE;
            else if (want_brk)
               st_nxt = lmu_pkg::TX_BREAK;
            else if (tx_load)
               st_nxt = lmu_pkg::TX_FRAME;
         lmu_pkg::TX_FRAME, lmu_pkg::TX_PRE, lmu_pkg::TX_BREAK:
            if (bit_end && bit_r == cur_len - 4'h1)
               st_nxt = lmu_pkg::TX_IDLE;
         default:
            st_nxt = lmu_pkg::TX_OFF;
      endcase
   end
   assign tx_fin = st_r == lmu_pkg::TX_FRAME && st_nxt == lmu_pkg::TX_IDLE;
   wire  te_pulse = tx_en && !te_d_r && tx_busy;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= lmu_pkg::TX_OFF;
         smp_r <= '0;
         bit_r <= '0;
         sh_r <= '1;
         nine_r <= 1'b0;
         pre_r <= 1'b0;
         brk_seen_r <= 1'b0;
         te_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         te_d_r <= tx_en;
         if (te_pulse)
            pre_r <= 1'b1;
         else if (st_nxt == lmu_pkg::TX_PRE)
            pre_r <= 1'b0;
         if (brk)
            brk_seen_r <= 1'b1;
         else if (st_nxt == lmu_pkg::TX_BREAK)
            brk_seen_r <= 1'b0;
         if (st_nxt != st_r) begin
            smp_r <= '0;
            bit_r <= '0;
         end else if (tick) begin
            smp_r <= smp_r + 4'h1;
            if (bit_end) begin
               bit_r <= bit_r + 4'h1;
               sh_r <= {1'b1, sh_r[10:1]};
            end
         end
         if (tx_load) begin
            nine_r <= nine;
            sh_r <= nine ? {1'b1, dat_p, 1'b0}
                         : {2'b11, dat_p[7:0], 1'b0};
         end else if (st_nxt == lmu_pkg::TX_BREAK && st_r != st_nxt)
            sh_r <= '0;
         else if (st_nxt == lmu_pkg::TX_PRE && st_r != st_nxt)
            sh_r <= '1;
      end
   end
   wire brk_low = st_r == lmu_pkg::TX_BREAK;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         txd <= 1'b1;
      else
         txd <= brk_low ? 1'b0 : (st_r == lmu_pkg::TX_FRAME ? sh_r[0] : 1'b1);
   end
   assign txd_oen = !((tx_en || rx_en) && !asleep);
   // ---------------------------------------------------------------
   // Synchronous clock output
   // ---------------------------------------------------------------
   // Data bits are 1..8 or 1..9; last one pulses only if enabled
   wire [3:0] last_db = nine_r ? 4'h9 : 4'h8;
   wire in_data = st_r == lmu_pkg::TX_FRAME && bit_r != 4'h0
                  && bit_r <= last_db;
   wire pulse_ok = in_data &&
      (bit_r != last_db || ctrl3_r[lmu_pkg::C3_LAST_BIT_PULSE_ENABLE]);
   wire first_half = smp_r <= lmu_pkg::HALF_SAMPLES;
   wire act = early_edge_phase ? first_half : !first_half;
   logic sclk_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sclk_r <= 1'b0;
      else
         sclk_r <= (pulse_ok && act) ? !idle_level_high : idle_level_high;
   end
   assign sync_clock_out = sclk_r;
   assign sync_clock_oen = !(ctrl3_r[lmu_pkg::C3_CKEN] && !asleep
                             && tx_en);
endmodule
`default_nettype wire

// File: testbench/lmu_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lmu_monitor (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Pins
   input wire logic        txd,
   input wire logic        txd_oen,
   input wire logic        sync_clock_out,
   input wire logic        sync_clock_oen,
   input wire logic        irq
);
   // ----
   // Helpers
   // ----
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [9:0] low_r;
   wire        rd_req = hsel && hready && htrans[1] && !hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_r <= 10'h000;
      end else begin
         low_r <= (txd || txd_oen) ? 10'h000 : low_r + 10'h001;
      end
   end
   // ----
   // Properties
   // ----
   a_ready_always: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_unmapped_zero: assert property (rd_req && haddr >= 8'h18 |=> hrdata == 0)
      else $error("unmapped read not zero");
   a_ctrl3_reserved: assert property (rd_req &&
      haddr == lmu_pkg::OFS_CTRL3 |=> hrdata[31:7] == 0 && hrdata[5:4] == 0)
      else $error("reserved ctrl3 bits set");
   a_irq_quiet: assert property ($rose(hresetn) |-> !irq)
      else $error("irq after reset");
   a_pins_rest: assert property ($rose(hresetn) |-> txd && txd_oen)
      else $error("txd not at rest");
   a_clk_needs_tx: assert property (!sync_clock_oen |-> !txd_oen)
      else $error("clock pin without transmitter");
   a_break_max: assert property (txd && low_r != 0 |-> low_r <= 10'h0E0)
      else $error("low run too long");
   c_break: cover property (txd && low_r > 10'h0A0);
   c_irq: cover property ($rose(irq));
   c_sclk: cover property (!sync_clock_oen && $changed(sync_clock_out));
endmodule
bind lmu_top lmu_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .txd(txd), .txd_oen(txd_oen),
   .sync_clock_out(sync_clock_out), .sync_clock_oen(sync_clock_oen),
   .irq(irq));
`default_nettype wire

// File: testbench/lmu_peer.sv
`timescale 1ns/100ps
`default_nettype none
module lmu_peer (
   // Clock
   input  wire logic       hclk,
   // Lines
   input  wire logic       txd,
   output logic            rxd,
   // Decoder setup
   input  wire logic       dec_on,
   input  wire logic [3:0] nb
);
   // ----
   // Frame decode, low runs, sender
   // ----
   logic [9:0] got;
   int         frames = 0;
   int         runs = 0;
   int         low_run = 0;
   int         low_cnt = 0;
   initial begin
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         if (dec_on) begin
            got = '0;
            repeat (8) @(posedge hclk);
            for (int i = 0; i <= nb; i++) begin
               repeat (16) @(posedge hclk);
               got[i] = txd;
            end
            frames++;
         end
      end
   end
   always @(posedge hclk) begin
      if (txd === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end else if (low_cnt != 0) begin
         low_run <= low_cnt;
         runs <= runs + 1;
         low_cnt <= 0;
      end
   end
   // Line rests high between frames, as if pulled up
   task automatic send(logic [9:0] w, int n);
      for (int i = -1; i <= n; i++) begin
         rxd <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : w[i];
         repeat (16) @(posedge hclk);
      end
   endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ----
   // Signals and notes
   // ----
   typedef struct {logic [31:0] e, m; string w;} lmu_note_t;
   logic        hclk, hresetn, hwrite, rxd, txd, txd_oen, irq, rd_dp;
   logic        hreadyout, hresp, sclk, sclk_oen, sq, dec_on;
   logic        nn, pe, od, lb, cp;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [3:0]  nb;
   logic [8:0]  d;
   logic [15:0] lens;
   logic [31:0] hwdata, hrdata, e;
   wire         hready = hreadyout;
   int          mismatches = 0, checks_done = 0, cyc = 0, pulses, i, r0;
   lmu_note_t   rq[$], fq[$], bq[$], n, f, b;
   lmu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rxd(rxd), .txd(txd), .txd_oen(txd_oen),
      .sync_clock_out(sclk), .sync_clock_oen(sclk_oen), .irq(irq));
   lmu_peer u_peer (.hclk(hclk), .txd(txd), .rxd(rxd), .dec_on(dec_on),
      .nb(nb));
   // ----
   // Tasks
   // ----
   task automatic chk(string w, logic [31:0] x, logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         mismatches++;
         $display("BAD %s exp %h got %h", w, x, g);
      end
   endtask
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] v);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= v;
      rd_dp <= !wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd_dp <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] x, logic [31:0] m);
      rq.push_back('{x, m, $sformatf("reg %h", a)});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic close_out;
      // A note still queued means its result never appeared
      if (rq.size() + fq.size() + bq.size() != 0) mismatches++;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ----
   // Clock, timeout, watchers
   // ----
   initial begin
      hclk = 1'b0;
      forever #10 hclk = !hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         close_out();
      end
   end
   always @(negedge hclk) begin
      if (sclk !== sq && sq === cp) pulses++;
      sq = sclk;
      if (rd_dp && hreadyout && rq.size() > 0) begin
         n = rq.pop_front();
         chk(n.w, n.e, hrdata & n.m);
      end
   end
   always @(u_peer.frames) begin
      if (fq.size() > 0) begin
         f = fq.pop_front();
         chk(f.w, f.e, {16'h0, pulses[3:0], 2'h0, u_peer.got} & f.m);
      end
   end
   always @(u_peer.runs) begin
      if (bq.size() > 0) begin
         b = bq.pop_front();
         chk(b.w, b.e, 32'((u_peer.low_run + 8) / 16));
      end
   end
   // ----
   // Tests
   // ----
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 8'h00;
      hwdata = 32'h0;
      rd_dp = 1'b0;
      dec_on = 1'b0;
      nb = 4'h8;
      cp = 1'b0;
      void'($urandom(97241));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(lmu_pkg::OFS_CTRL1, 32'h0, 32'h7F);
      rd(lmu_pkg::OFS_CTRL2, 32'h0, 32'hFF);
      rd(lmu_pkg::OFS_CTRL3, 32'h0, 32'hFF);
      rd(lmu_pkg::OFS_STATUS, 32'hC0, 32'hFF);
      bus(1'b1, 8'h18, 32'hFF);
      rd(8'h18, 32'h0, 32'hFFFFFFFF);
      bus(1'b1, lmu_pkg::OFS_CTRL3, 32'hFF);
      rd(lmu_pkg::OFS_CTRL3, 32'h4F, 32'hFF);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h80 >> i);
         @(negedge hclk);
         chk("irq", {31'h0, i < 2}, {31'h0, irq});
         @(posedge hclk);
      end
      bus(1'b1, lmu_pkg::OFS_BAUD, 32'h0);
      $display("test regs and irq done");
      for (int k = 0; k < 8; k++) begin
         d = 9'($urandom);
         {od, pe, nn} = 3'(k);
         lb = pe ^ od;
         cp = nn ^ pe;
         bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h0);
         bus(1'b1, lmu_pkg::OFS_CTRL3, {29'h1, cp, od, lb});
         bus(1'b1, lmu_pkg::OFS_CTRL1,
            {25'h0, d[8], 1'b0, nn, 1'b0, pe, od, 1'b0});
         bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h8);
         e = {24'h0, d[7:0]};
         if (pe && !nn) e[7] = ^d[6:0] ^ od;
         e[8] = nn ? (pe ? ^d[7:0] ^ od : d[8]) : 1'b1;
         e[9] = nn;
         e[15:12] = 4'h7 + {3'h0, nn} + {3'h0, lb};
         nb <= 4'h8 + {3'h0, nn};
         dec_on <= 1'b1;
         pulses = 0;
         fq.push_back('{e, 32'hF3FF, "frame"});
         r0 = u_peer.frames;
         bus(1'b1, lmu_pkg::OFS_DATA, {23'h0, d});
         for (i = 0; i < 800 && u_peer.frames == r0; i++) @(posedge hclk);
         @(negedge hclk);
         chk("clock rest", {31'h0, cp}, {31'h0, sclk});
         chk("clock oen", 32'h0, {31'h0, sclk_oen});
         // Let the stop bit finish before the frame setup changes
         repeat (16) @(posedge hclk);
      end
      $display("test frames done");
      dec_on <= 1'b0;
      lens = {lmu_pkg::BRK_LEN_LIN9, lmu_pkg::BRK_LEN_LIN8,
         lmu_pkg::BRK_LEN_9, lmu_pkg::BRK_LEN_8};
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, lmu_pkg::OFS_CTRL3, {25'h0, j[1], 6'h0});
         bus(1'b1, lmu_pkg::OFS_CTRL1, {27'h0, j[0], 4'h0});
         bq.push_back('{{28'h0, lens[j*4+:4]}, 32'hF, "break"});
         r0 = u_peer.runs;
         bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h9);
         bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h8);
         for (i = 0; i < 800 && u_peer.runs == r0; i++) @(posedge hclk);
      end
      $display("test breaks done");
      d = 9'($urandom);
      bus(1'b1, lmu_pkg::OFS_CTRL1, 32'h5);
      bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h24);
      u_peer.send({2'h0, ~^d[6:0], d[6:0]}, 8);
      for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge hclk);
      rd(lmu_pkg::OFS_STATUS, 32'h21, 32'h21);
      bus(1'b1, lmu_pkg::OFS_CTRL1, 32'hD);
      bus(1'b1, lmu_pkg::OFS_CTRL2, 32'h26);
      rd(lmu_pkg::OFS_CTRL2, 32'h24, 32'hFF);
      rd(lmu_pkg::OFS_DATA, {25'h0, d[6:0]}, 32'h7F);
      @(negedge hclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      @(posedge hclk);
      $display("test receive done");
      close_out();
   end
endmodule
`default_nettype wire
